// *** shared/acpc_pkg.sv ***
// Purpose: constants and types for the converter pin control block
// Assumes: 200 MHz pclk, APB register access with 32-bit data
// Notes: What this block does is listed below, one line per tag
//
// What this block does
// - first variant: ground 0100001, supply 0100010
// - second variant: ground 0100011, supply 0100100
// - floating select pin gives address 0100000
// - mode bit zero: dual channel, supply reference
// - start rising edge powers up, about 1 us
// - start falling edge holds and starts conversion
// - alert output flags results outside limits
// - busy output asserted while converting
// - power down automatically after each conversion
// - bus access works while powered down
package acpc_pkg;
    // ************************************************************
    // register map, byte addresses
    // ************************************************************
    localparam logic [7:0] ACPC_OFS_CONFIG = 8'h00;
    localparam logic [7:0] ACPC_OFS_LIMIT_HIGH = 8'h04;
    localparam logic [7:0] ACPC_OFS_LIMIT_LOW = 8'h08;
    localparam logic [7:0] ACPC_OFS_RESULT = 8'h0c;
    localparam logic [7:0] ACPC_OFS_ADDRESS = 8'h10;

    // config field positions
    localparam int ACPC_CFG_ALERT_EN = 0;
    localparam int ACPC_CFG_BUSY_SEL = 1;
    localparam int ACPC_CFG_CHANNEL_MODE = 6;
    localparam int ACPC_CFG_WIDTH = 7;
    localparam logic [6:0] ACPC_CFG_RESET = 7'h00;

    // result register status positions
    localparam int ACPC_RES_INVALID = 15;
    localparam int ACPC_RES_ALERT = 16;
    localparam int ACPC_RES_POWERED = 17;
    localparam int ACPC_RES_BUSY = 18;
    localparam int ACPC_RES_CHANNEL = 19;

    // limits and data width
    localparam int ACPC_DATA_W = 12;
    localparam logic [11:0] ACPC_LIMIT_HIGH_RESET = 12'hfff;
    localparam logic [11:0] ACPC_LIMIT_LOW_RESET = 12'h000;

    // bus addresses by variant and select pin
    localparam logic [6:0] ACPC_ADDR_V0_GND = 7'h21;
    localparam logic [6:0] ACPC_ADDR_V0_VDD = 7'h22;
    localparam logic [6:0] ACPC_ADDR_V1_GND = 7'h23;
    localparam logic [6:0] ACPC_ADDR_V1_VDD = 7'h24;
    localparam logic [6:0] ACPC_ADDR_FLOAT = 7'h20;

    // timing
    localparam int ACPC_CLK_PERIOD_PS = 5000;
    localparam int ACPC_POWERUP_NS = 1000;
    // least time: round up, never below one cycle
    localparam int ACPC_POWERUP_CYC_RAW =
        (ACPC_POWERUP_NS * 1000 + ACPC_CLK_PERIOD_PS - 1) / ACPC_CLK_PERIOD_PS;
    localparam int ACPC_POWERUP_CYC =
        (ACPC_POWERUP_CYC_RAW < 1) ? 1 : ACPC_POWERUP_CYC_RAW;
    localparam int ACPC_CNT_W = 12;
    localparam logic [11:0] ACPC_CONV_CYC_DEFAULT = 12'h190;

    // converter state, gray along idle -> power -> convert
    typedef enum logic [1:0] {
        ACPC_IDLE = 2'b00,
        ACPC_POWER = 2'b01,
        ACPC_CONVERT = 2'b11
    } acpc_state_t;
endpackage

// *** logic/acpc_top.sv ***
// Purpose: pin control of a two-channel 12-bit converter
// Assumes: start and select pins are asynchronous to pclk
// Notes: registers over APB, zero-wait answers
//
// Decided for this implementation: the register offsets and the APB slave port.
`timescale 1ns/1ps
`default_nettype none
module acpc_top
    import acpc_pkg::*;
#(
    parameter bit VARIANT = 1'b0,           // which address set the part uses
    parameter logic [11:0] CONV_CYCLES = ACPC_CONV_CYC_DEFAULT
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic convert_start_pin,
    input wire logic address_select_pin_low,   // pin seen tied to ground
    input wire logic address_select_pin_high,  // pin seen tied to supply
    input wire logic [11:0] converter_code,    // sar result, same clock
    output logic [6:0] bus_address,
    output logic converter_power,
    output logic track_hold,                  // high while holding
    output logic second_channel_select,
    output logic second_input_or_reference_pin_is_ref,
    output logic alert_busy_out,
    output logic alert_busy_oe
);
    // ************************************************************
    // pin synchronisers
    // ************************************************************
    logic [2:0] sync1_q;  // first stage, read only by second stage
    logic [2:0] sync2_q;
    logic start_prev_q;   // for edge detection
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sync1_q <= 3'h0;
            sync2_q <= 3'h0;
            start_prev_q <= 1'b0;
        end else begin
            sync1_q <= {address_select_pin_high, address_select_pin_low,
                        convert_start_pin};
            sync2_q <= sync1_q;
            start_prev_q <= sync2_q[0];
        end
    end
    wire start_rise = sync2_q[0] & ~start_prev_q;
    wire start_fall = ~sync2_q[0] & start_prev_q;

    // ************************************************************
    // bus address selection
    // ************************************************************
    // neither level seen means the pin floats
    wire [6:0] addr_gnd = VARIANT ? ACPC_ADDR_V1_GND : ACPC_ADDR_V0_GND;
    wire [6:0] addr_vdd = VARIANT ? ACPC_ADDR_V1_VDD : ACPC_ADDR_V0_VDD;
    wire [6:0] address_d = sync2_q[1] ? addr_gnd :
                           sync2_q[2] ? addr_vdd : ACPC_ADDR_FLOAT;
    logic [6:0] address_q;
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            address_q <= ACPC_ADDR_FLOAT;
        end else begin
            address_q <= address_d;
        end
    end

    // ************************************************************
    // apb slave
    // ************************************************************
    logic [6:0] config_q;
    logic [11:0] limit_high_q;
    logic [11:0] limit_low_q;
    logic [11:0] result_q;
    logic invalid_q;
    logic alert_q;
    logic pready_q;
    logic pslverr_q;
    logic [31:0] prdata_q;
    logic chan_q;              // channel of the latest conversion
    acpc_state_t state_q;

    wire [7:0] offs = paddr[7:0];
    wire hit_cfg = (offs == ACPC_OFS_CONFIG);
    wire hit_hi = (offs == ACPC_OFS_LIMIT_HIGH);
    wire hit_lo = (offs == ACPC_OFS_LIMIT_LOW);
    wire hit_res = (offs == ACPC_OFS_RESULT);
    wire hit_adr = (offs == ACPC_OFS_ADDRESS);
    wire mapped = (paddr[31:8] == 24'h000000) &
                  (hit_cfg | hit_hi | hit_lo | hit_res | hit_adr);
    // access cycle in which the answer is given
    wire access = psel & penable & pready_q;
    wire wr_ok = access & pwrite & mapped;
    // no check on power state: the bus is served at all times
    wire setup = psel & ~pready_q;

    // channel bit is that of the latest conversion started, not of the live mux
    wire [31:0] status_word = {12'h000, chan_q,
        state_q == ACPC_CONVERT, state_q != ACPC_IDLE, alert_q,
        invalid_q, 3'h0, result_q};
    wire [31:0] rdata_d = hit_cfg ? {25'h0, config_q} :
                          hit_hi ? {20'h0, limit_high_q} :
                          hit_lo ? {20'h0, limit_low_q} :
                          hit_res ? status_word :
                          hit_adr ? {25'h0, address_q} : 32'h0;

    // answer one cycle after setup, so access ends at first edge
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready_q <= 1'b0;
            pslverr_q <= 1'b0;
            prdata_q <= 32'h0;
        end else begin
            pready_q <= setup;
            pslverr_q <= setup & ~mapped;
            prdata_q <= (setup & ~pwrite) ? rdata_d : 32'h0;
        end
    end

    // ************************************************************
    // configuration storage
    // ************************************************************
    // result and address registers are read only; writes are dropped
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            config_q <= ACPC_CFG_RESET;
            limit_high_q <= ACPC_LIMIT_HIGH_RESET;
            limit_low_q <= ACPC_LIMIT_LOW_RESET;
        end else if (wr_ok) begin
            if (hit_cfg) begin
                config_q <= pwdata[ACPC_CFG_WIDTH-1:0];
            end
            if (hit_hi) begin
                limit_high_q <= pwdata[ACPC_DATA_W-1:0];
            end
            if (hit_lo) begin
                limit_low_q <= pwdata[ACPC_DATA_W-1:0];
            end
        end
    end

    // ************************************************************
    // conversion sequencer
    // ************************************************************
    logic [11:0] cnt_q;        // power-up, then conversion cycles
    logic pick_q;              // alternates channels in dual mode
    wire single = config_q[ACPC_CFG_CHANNEL_MODE];
    wire chan_d = single ? 1'b0 : pick_q;
    wire pu_done = (cnt_q >= ACPC_POWERUP_CYC[11:0]);
    wire conv_end = (state_q == ACPC_CONVERT) && (cnt_q == 12'h001);
    wire out_range = (result_q > limit_high_q) | (result_q < limit_low_q);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_q <= ACPC_IDLE;
            cnt_q <= 12'h000;
            chan_q <= 1'b0;
            pick_q <= 1'b0;
            invalid_q <= 1'b0;
            result_q <= 12'h000;
        end else begin
            case (state_q)
                ACPC_IDLE: begin
                    // a stray falling edge without power-up is ignored
                    if (start_rise) begin
                        state_q <= ACPC_POWER;
                        cnt_q <= 12'h000;
                    end
                end
                ACPC_POWER: begin
                    if (start_fall) begin
                        state_q <= ACPC_CONVERT;
                        cnt_q <= CONV_CYCLES;
                        invalid_q <= ~pu_done;
                        chan_q <= chan_d;
                        pick_q <= single ? 1'b0 : ~pick_q;
                    end else if (!pu_done) begin
                        cnt_q <= cnt_q + 12'h001;
                    end
                end
                ACPC_CONVERT: begin
                    if (conv_end) begin
                        state_q <= ACPC_IDLE;
                        result_q <= converter_code;
                    end else begin
                        cnt_q <= cnt_q - 12'h001;
                    end
                end
                default: begin
                    state_q <= ACPC_IDLE;
                end
            endcase
        end
    end

    // ************************************************************
    // shared open-drain output
    // ************************************************************
    // alert compares the latest stored result against the limits
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            alert_q <= 1'b0;
        end else begin
            alert_q <= config_q[ACPC_CFG_ALERT_EN] & out_range;
        end
    end
    wire busy_sel = config_q[ACPC_CFG_BUSY_SEL];
    wire conv_next = (state_q == ACPC_POWER && start_fall) ||
                     (state_q == ACPC_CONVERT && !conv_end);
    wire drive_d = busy_sel ? conv_next :
                   (config_q[ACPC_CFG_ALERT_EN] & out_range);

    logic oe_q;
    logic power_q;
    logic hold_q;
    logic sel2_q;
    logic ref_q;
    logic od_low_q;  // open-drain pin only ever pulls low
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            oe_q <= 1'b0;
            power_q <= 1'b0;
            hold_q <= 1'b0;
            sel2_q <= 1'b0;
            ref_q <= 1'b0;
            od_low_q <= 1'b0;
        end else begin
            oe_q <= drive_d;
            power_q <= (state_q == ACPC_IDLE) ? start_rise :
                       !conv_end;
            hold_q <= conv_next;
            sel2_q <= conv_next & ((state_q == ACPC_POWER) ? chan_d : chan_q);
            ref_q <= single;
            od_low_q <= 1'b0;
        end
    end

    assign prdata = prdata_q;
    assign pready = pready_q;
    assign pslverr = pslverr_q;
    assign bus_address = address_q;
    assign converter_power = power_q;
    assign track_hold = hold_q;
    assign second_channel_select = sel2_q;
    assign second_input_or_reference_pin_is_ref = ref_q;
    assign alert_busy_out = od_low_q;
    assign alert_busy_oe = oe_q;

    // ************************************************************
    // checks
    // ************************************************************
    AST_ADDR_FLOAT: assert property (@(posedge pclk) disable iff (!presetn)
        !sync2_q[1] && !sync2_q[2] |=> bus_address == ACPC_ADDR_FLOAT)
        else $error("float address wrong");
    AST_ADDR_GND: assert property (@(posedge pclk) disable iff (!presetn)
        sync2_q[1] |=> bus_address == (VARIANT ? ACPC_ADDR_V1_GND
                                               : ACPC_ADDR_V0_GND))
        else $error("ground address wrong");
    AST_ADDR_VDD: assert property (@(posedge pclk) disable iff (!presetn)
        !sync2_q[1] && sync2_q[2] |=> bus_address == (VARIANT ?
            ACPC_ADDR_V1_VDD : ACPC_ADDR_V0_VDD))
        else $error("supply address wrong");
    AST_REF_MODE: assert property (@(posedge pclk) disable iff (!presetn)
        ##1 second_input_or_reference_pin_is_ref == $past(single))
        else $error("reference selection wrong");
    AST_SINGLE_CH: assert property (@(posedge pclk) disable iff (!presetn)
        single && state_q == ACPC_POWER && start_fall |=> !second_channel_select)
        else $error("second channel used in single mode");
    AST_POWER_UP: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == ACPC_IDLE && start_rise |=> state_q == ACPC_POWER
        ##1 converter_power)
        else $error("no power-up on rising edge");
    AST_HOLD: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == ACPC_POWER && start_fall |=> state_q == ACPC_CONVERT
        && track_hold)
        else $error("no hold on falling edge");
    AST_SHORT_PULSE: assert property (@(posedge pclk) disable iff (!presetn)
        state_q == ACPC_POWER && start_fall && !pu_done |=> invalid_q)
        else $error("short pulse not flagged");
    AST_BUSY: assert property (@(posedge pclk) disable iff (!presetn)
        busy_sel && $past(busy_sel) && state_q == ACPC_CONVERT
        && !conv_end |=> alert_busy_oe)
        else $error("busy not shown");
    AST_AUTO_DOWN: assert property (@(posedge pclk) disable iff (!presetn)
        conv_end |=> state_q == ACPC_IDLE && !converter_power)
        else $error("no power-down after conversion");
    AST_BUS_IDLE: assert property (@(posedge pclk) disable iff (!presetn)
        psel && !penable && state_q == ACPC_IDLE |=> pready)
        else $error("bus stalled while powered down");
    AST_ALERT: assert property (@(posedge pclk) disable iff (!presetn)
        !busy_sel && config_q[ACPC_CFG_ALERT_EN] && out_range
        && $stable(config_q) |=> alert_busy_oe)
        else $error("alert not raised");
    COV_CONVERT: cover property (@(posedge pclk) conv_end);
    COV_INVALID: cover property (@(posedge pclk) $rose(invalid_q));
    COV_ALERT: cover property (@(posedge pclk) $rose(alert_q));
    COV_WRITE: cover property (@(posedge pclk) wr_ok && hit_cfg);
endmodule
`default_nettype wire

// *** verification/acpc_start_model.sv ***
// Purpose: far-side model driving the convert-start pin and sar code
// Assumes: its own 64 ns clock, unrelated in phase to pclk
// Notes: the bench asks for short pulses only where it wants bad results
`timescale 1ns/1ps
`default_nettype none
module acpc_start_model (
    output logic convert_start_pin,
    output logic [11:0] converter_code
);
    // ************************************************************
    // link clock and pulse driver
    // ************************************************************
    logic lclk = 1'b0; // free-running driver clock, never reaches the dut

    // half period of the 64 ns driver clock
    always #32 lclk = ~lclk;

    // idle: pin low, code parked at zero
    initial begin
        convert_start_pin = 1'b0;
        converter_code = 12'h000;
    end

    // one start pulse; hi counts driver clock periods held high
    // a hold of 16 periods or more clears the 1 us power-up time
    task automatic pulse(input int hi, input logic [11:0] c);
        @(posedge lclk);
        converter_code <= c;
        convert_start_pin <= 1'b1;
        repeat (hi) @(posedge lclk);
        convert_start_pin <= 1'b0;
    endtask
endmodule
`default_nettype wire

// *** verification/acpc_top_bench.sv ***
// Purpose: self-checking bench for the converter pin control block
// Assumes: conversions shortened to 8 cycles through CONV_CYCLES
// Notes: expected values come from the bench model, never the dut
`timescale 1ns/1ps
`default_nettype none
module acpc_top_bench;
    import acpc_pkg::*;
    // ************************************************************
    // nets, counters and model state
    // ************************************************************
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [31:0] paddr = 32'h0;
    logic [31:0] pwdata = 32'h0;
    logic sel_low = 1'b0;  // select pin tied to ground
    logic sel_high = 1'b0; // select pin tied to supply
    wire logic [31:0] prdata;
    wire logic pready, pslverr, start_pin, pwr, hold, chan2, is_ref, ab_oe;
    wire logic ab_out; // open-drain data level, must stay low
    wire logic [11:0] code;
    wire logic [6:0] addr0, addr1;
    int miscompares = 0;
    int cmp_count = 0;
    logic chan_q = 1'b0; // model: channel of next dual-mode conversion
    logic [6:0] exp0 [3] = '{7'h21, 7'h22, 7'h20}; // first variant
    logic [6:0] exp1 [3] = '{7'h23, 7'h24, 7'h20}; // second variant

    // 200 MHz clock
    always #2.5 pclk = ~pclk;

    acpc_top #(.VARIANT(1'b0), .CONV_CYCLES(12'h008)) u_dut (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .convert_start_pin(start_pin),
        .address_select_pin_low(sel_low), .address_select_pin_high(sel_high),
        .converter_code(code), .bus_address(addr0), .converter_power(pwr),
        .track_hold(hold), .second_channel_select(chan2),
        .second_input_or_reference_pin_is_ref(is_ref),
        .alert_busy_out(ab_out), .alert_busy_oe(ab_oe));

    // second variant: only its address set is of interest
    acpc_top #(.VARIANT(1'b1), .CONV_CYCLES(12'h008)) u_dut_v1 (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(),
        .pready(), .pslverr(), .convert_start_pin(start_pin),
        .address_select_pin_low(sel_low), .address_select_pin_high(sel_high),
        .converter_code(code), .bus_address(addr1), .converter_power(),
        .track_hold(), .second_channel_select(),
        .second_input_or_reference_pin_is_ref(),
        .alert_busy_out(), .alert_busy_oe());

    acpc_start_model u_host (.convert_start_pin(start_pin),
        .converter_code(code));

    // ************************************************************
    // shared tasks
    // ************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        cmp_count++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic tally_and_finish();
        if (miscompares == 0 && cmp_count > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask

    // a bounded wait ran out: count it and close the run
    task automatic hang();
        miscompares++;
        $display("[ERR] %0t wait ran out", $time);
        tally_and_finish();
    endtask

    // one apb transfer; waits for pready instead of assuming zero wait
    task automatic apb(input logic w, input logic [7:0] a,
                       input logic [31:0] d, output logic [31:0] r,
                       output logic e);
        int n;
        n = 0;
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= {24'h0, a};
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        // pready, read data and error are all taken at one rising edge
        @(posedge pclk);
        while (pready !== 1'b1) begin
            n++;
            if (n > 50) hang();
            @(posedge pclk);
        end
        r = prdata;
        e = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // wait for power (which=0) or hold (which=1) to reach lvl
    task automatic wait_sig(input logic which, input logic lvl);
        int n;
        n = 0;
        @(negedge pclk);
        while ((which ? hold : pwr) !== lvl) begin
            @(negedge pclk);
            n++;
            if (n > 3000) hang();
        end
    endtask

    // full conversion: configure, pulse, watch pins, read result back
    task automatic conv(input logic [6:0] cfg, input int hi,
                        input logic [11:0] c, input logic [11:0] lhi,
                        input logic [11:0] llo);
        logic [31:0] r;
        logic e;
        logic ch;
        ch = cfg[6] ? 1'b0 : chan_q;
        apb(1'b1, ACPC_OFS_CONFIG, {25'h0, cfg}, r, e);
        apb(1'b1, ACPC_OFS_LIMIT_HIGH, {20'h0, lhi}, r, e);
        apb(1'b1, ACPC_OFS_LIMIT_LOW, {20'h0, llo}, r, e);
        @(negedge pclk);
        chk(is_ref, cfg[6]);
        fork
            u_host.pulse(hi, c);
        join_none
        wait_sig(1'b0, 1'b1);
        chk(start_pin, 1'b1);
        wait_sig(1'b1, 1'b1);
        chk(start_pin, 1'b0);
        chk(chan2, ch);
        if (cfg[1]) chk(ab_oe, 1'b1);
        chk(ab_out, 1'b0);
        wait_sig(1'b0, 1'b0);
        chk(hold, 1'b0);
        repeat (3) @(negedge pclk);
        chk(ab_oe, cfg[0] & ~cfg[1] & (c > lhi | c < llo));
        apb(1'b0, ACPC_OFS_RESULT, 32'h0, r, e);
        chk(r[11:0], c);
        chk(r[15], hi < 16);
        chk(r[19], ch);
        chan_q = cfg[6] ? 1'b0 : ~chan_q;
    endtask

    // ************************************************************
    // main sequence
    // ************************************************************
    initial begin
        logic [31:0] r;
        logic e;
        void'($urandom(32'h2bd4));
        repeat (12) @(posedge pclk);
        presetn <= 1'b1;
        // reset values, read while the converter sleeps
        apb(1'b0, ACPC_OFS_CONFIG, 32'h0, r, e);
        chk(r, 32'h0);
        apb(1'b0, ACPC_OFS_LIMIT_HIGH, 32'h0, r, e);
        chk(r, 32'hfff);
        apb(1'b0, ACPC_OFS_LIMIT_LOW, 32'h0, r, e);
        chk(r, 32'h0);
        // unmapped word: error answer, data zero
        apb(1'b0, 8'h14, 32'h0, r, e);
        chk(e, 1'b1);
        chk(r, 32'h0);
        // select pin at ground, supply and floating
        for (int i = 0; i < 3; i++) begin
            @(posedge pclk);
            sel_low <= (i == 0);
            sel_high <= (i == 1);
            repeat (5) @(negedge pclk);
            chk(addr0, exp0[i]);
            chk(addr1, exp1[i]);
            apb(1'b0, ACPC_OFS_ADDRESS, 32'h0, r, e);
            chk(r[6:0], exp0[i]);
        end
        // dual mode, busy function, channels alternate
        conv(7'h02, 20, 12'($urandom), 12'hfff, 12'h000);
        conv(7'h02, 20, 12'($urandom), 12'hfff, 12'h000);
        // single mode, alert above, inside and below the limits
        conv(7'h41, 20, 12'h900, 12'h800, 12'h100);
        conv(7'h41, 20, 12'h400, 12'h800, 12'h100);
        conv(7'h41, 20, 12'h050, 12'h800, 12'h100);
        // start pulse too short: result flagged invalid
        conv(7'h40, 5, 12'($urandom), 12'hfff, 12'h000);
        tally_and_finish();
    end
endmodule
`default_nettype wire
